//--- hdl/wlch_pkg.sv
// Purpose: Shared constants for the raw sector write command handler
// Assumes: Ten-byte command blocks, byte-wide data stream
// Notes: Sizes are plain defaults, not tied to any product
package wlch_pkg;
   localparam logic [7:0] OP_RAW_WR_VU = 8'hea;
   localparam logic [7:0] OP_RAW_WR_STD = 8'h3f;
   localparam logic [7:0] OP_BUF_WR = 8'h3b;
   localparam int CDB_LEN = 10;
   localparam int CDB_LUN_BYTE = 1;
   localparam int CDB_LUN_MSB = 7;
   localparam int CDB_LUN_LSB = 5;
   localparam int CDB_ADDR_FIRST = 2;
   localparam int CDB_LEN_MSB = 7;
   localparam int CDB_LEN_LSB = 8;
   localparam int CDB_CTRL_BYTE = 9;
   localparam int ECC_BYTES = 6;
   localparam int BUF_HDR_BYTES = 4;
   localparam logic [15:0] BUF_SIZE = 16'h2000;
   localparam logic [15:0] PHYS_SECTOR_BYTES = 16'h0200;
   localparam logic [31:0] PHYS_SECTOR_COUNT = 32'h0010_0000;
   localparam logic [7:0] SENSE_ILLEGAL_REQ = 8'h05;
   localparam logic [7:0] ASC_BAD_ADDR = 8'h21;
   localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
   localparam logic [7:0] STAT_GOOD = 8'h00;
   localparam logic [7:0] STAT_CHECK = 8'h02;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CDB = 3'b001,
      ST_CHECK = 3'b010,
      ST_DATA = 3'b011,
      ST_DONE = 3'b100
   } wlch_state_e;
endpackage

//--- hdl/wlch_write_long.sv
// Purpose: Decodes buffer and raw sector writes, streams raw data to media
// Assumes: Command bytes and data bytes arrive as one-cycle strobes on mclk
// Notes: Media sees absolute byte addresses, sector base plus offset, correction bytes verbatim
// Notes: Opcodes other than the three handled here end good with no action
// Function
// - A buffer write longer than the buffer ends with check status and sense 05h/24h.
// - A raw write moves exactly one sector then six correction bytes stored as received.
// - Both opcode EAh and opcode 3Fh start the same raw sector write.
// - Command bytes 7 and 8 of a raw write are ignored as a length.
// - The raw write address is bytes 2 to 5, most significant first.
// - The physical location uses the physical sector size.
// - An out of range raw write address ends with check status and sense 05h/21h.
// - The unit number is the three-bit field of command byte 1.
// - The buffer write length compared to the buffer includes the four header bytes.
`timescale 1ns/1ns
`default_nettype none
module wlch_write_long (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // Command bytes
   input wire logic cdb_valid,
   input wire logic [7:0] cdb_byte,
   // Data out bytes
   input wire logic data_valid,
   input wire logic [7:0] data_byte,
   output logic data_req,
   // Media write port
   output logic media_we,
   output logic [31:0] media_addr,
   output logic [7:0] media_data,
   output logic media_ecc,
   // Buffer write acceptance
   output logic buf_ok,
   // Completion
   output logic done,
   output logic [7:0] status,
   output logic [7:0] sense_key,
   output logic [7:0] sense_code,
   output logic [2:0] lun
);
   import wlch_pkg::*;

   typedef struct packed {
      // Command capture and progress
      wlch_state_e st;
      logic [3:0] idx;
      logic [7:0] op;
      logic [31:0] blk;
      logic [15:0] blen;
      logic [15:0] cnt;
      // Registered outputs, one register field each
      logic data_req;
      logic media_we;
      logic [31:0] media_addr;
      logic [7:0] media_data;
      logic media_ecc;
      logic buf_ok;
      logic done;
      logic [7:0] status;
      logic [7:0] sense_key;
      logic [7:0] sense_code;
      logic [2:0] lun;
   } wlch_s;

   wlch_s s_reg;
   wlch_s s_next;
   logic raw_op;
   logic [31:0] sector_base;
   logic buf_op;
   logic [31:0] byte_addr;
   logic cdb_take;
   logic data_take;
   logic lun_byte;
   logic addr_byte;
   logic len_hi_byte;
   logic len_lo_byte;
   logic ctrl_byte;
   logic addr_ok;
   logic len_ok;
   logic ecc_phase;
   logic last_byte;

   ////////////////////////////////////////////////////////////////////
   assign raw_op = (s_reg.op == OP_RAW_WR_VU) || (s_reg.op == OP_RAW_WR_STD);
   assign buf_op = (s_reg.op == OP_BUF_WR);
   // Product is cut to 32 bits; any block that passes the range check fits without loss
   assign sector_base = 32'(s_reg.blk * 32'(PHYS_SECTOR_BYTES));
   assign byte_addr = sector_base + 32'(s_reg.cnt);

   // Strobes outside their phase are dropped, not queued
   assign cdb_take = cdb_valid && ((s_reg.st == ST_IDLE) || (s_reg.st == ST_CDB));
   assign data_take = data_valid && s_reg.data_req && (s_reg.st == ST_DATA);
   assign lun_byte = (s_reg.idx == 4'(CDB_LUN_BYTE));
   assign addr_byte = (s_reg.idx >= 4'(CDB_ADDR_FIRST)) && (s_reg.idx < 4'(CDB_ADDR_FIRST + 4));
   assign len_hi_byte = (s_reg.idx == 4'(CDB_LEN_MSB));
   assign len_lo_byte = (s_reg.idx == 4'(CDB_LEN_LSB));
   assign ctrl_byte = (s_reg.idx == 4'(CDB_CTRL_BYTE));

   // Limits; the buffer length already counts its header bytes
   assign addr_ok = (s_reg.blk < PHYS_SECTOR_COUNT);
   assign len_ok = (s_reg.blen <= BUF_SIZE + 16'(BUF_HDR_BYTES));
   assign ecc_phase = (s_reg.cnt >= PHYS_SECTOR_BYTES);
   assign last_byte = (s_reg.cnt == PHYS_SECTOR_BYTES + 16'(ECC_BYTES - 1));

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.media_we = 1'b0;
      s_next.done = 1'b0;
      s_next.buf_ok = 1'b0;
      case (s_reg.st)
         ST_IDLE: begin
            // Byte 0 is the opcode; any value is taken here
            if (cdb_take) begin
               s_next.op = cdb_byte;
               s_next.idx = 4'h1;
               s_next.blk = 32'h0;
               s_next.blen = 16'h0;
               s_next.st = ST_CDB;
            end
         end
         ST_CDB: begin
            if (cdb_take) begin
               if (lun_byte) begin
                  s_next.lun = cdb_byte[CDB_LUN_MSB:CDB_LUN_LSB];
               end else if (addr_byte) begin
                  // Shifted in most significant byte first
                  s_next.blk = {s_reg.blk[23:0], cdb_byte};
               end else if (len_hi_byte) begin
                  // Raw writes keep this but never use it as a length
                  s_next.blen[15:8] = cdb_byte;
               end else if (len_lo_byte) begin
                  s_next.blen[7:0] = cdb_byte;
               end
               // Control byte is accepted without effect
               if (ctrl_byte) begin
                  s_next.st = ST_CHECK;
               end
               s_next.idx = s_reg.idx + 4'h1;
            end
         end
         ST_CHECK: begin
            s_next.cnt = 16'h0;
            s_next.status = STAT_GOOD;
            s_next.sense_key = 8'h00;
            s_next.sense_code = 8'h00;
            s_next.st = ST_DONE;
            if (raw_op) begin
               if (!addr_ok) begin
                  // Rejected before data out, so the medium is never touched
                  s_next.status = STAT_CHECK;
                  s_next.sense_key = SENSE_ILLEGAL_REQ;
                  s_next.sense_code = ASC_BAD_ADDR;
               end else begin
                  s_next.data_req = 1'b1;
                  s_next.st = ST_DATA;
               end
            end else if (buf_op) begin
               if (!len_ok) begin
                  s_next.status = STAT_CHECK;
                  s_next.sense_key = SENSE_ILLEGAL_REQ;
                  s_next.sense_code = ASC_BAD_FIELD;
               end else begin
                  s_next.buf_ok = 1'b1;
               end
            end else begin
               // Other opcodes are not ours: plain good completion
               s_next.st = ST_DONE;
            end
         end
         ST_DATA: begin
            // Extra bytes are refused by dropping data_req after the last
            if (data_take) begin
               s_next.media_we = 1'b1;
               s_next.media_data = data_byte;
               s_next.media_ecc = ecc_phase;
               s_next.media_addr = byte_addr;
               s_next.cnt = s_reg.cnt + 16'h1;
               if (last_byte) begin
                  s_next.data_req = 1'b0;
                  s_next.st = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            // Status and sense stay until the next check cycle
            s_next.done = 1'b1;
            s_next.st = ST_IDLE;
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   // Clock enable low freezes every field, outputs included
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign data_req = s_reg.data_req;
   assign media_we = s_reg.media_we;
   assign media_addr = s_reg.media_addr;
   assign media_data = s_reg.media_data;
   assign media_ecc = s_reg.media_ecc;
   assign buf_ok = s_reg.buf_ok;
   assign done = s_reg.done;
   assign status = s_reg.status;
   assign sense_key = s_reg.sense_key;
   assign sense_code = s_reg.sense_code;
   assign lun = s_reg.lun;
endmodule
`default_nettype wire

//--- verification/wlch_initiator.sv
// Purpose: Initiator model feeding data out bytes
// Assumes: One sector plus six correction bytes per raw write
// Notes: Idle data line shows the inverse of its last value
`timescale 1ns/1ns
`default_nettype none
module wlch_initiator (
   // Control
   input wire logic mclk,
   input wire logic data_req,
   input wire logic slow,
   // Data out
   output logic data_valid,
   output logic [7:0] data_byte
);
   logic [9:0] cnt_reg = 10'h000;
   logic tick_reg = 1'b0;
   wire logic send = data_req && cnt_reg < 10'h206 && (!slow || tick_reg);
   always @(posedge mclk) begin
      tick_reg <= ~tick_reg;
      data_valid <= send;
      data_byte <= send ? cnt_reg[7:0] ^ 8'h5a : ~data_byte;
      cnt_reg <= data_req ? cnt_reg + 10'(send) : 10'h000;
   end
endmodule
`default_nettype wire

//--- verification/wlch_properties.sv
// Purpose: Port checks for the raw write handler
// Assumes: Clock enable held high
// Notes: Bound to the handler
`timescale 1ns/1ns
`default_nettype none
module wlch_properties import wlch_pkg::*; (
   // Clock and stream
   input wire logic mclk,
   input wire logic rst,
   input wire logic data_valid,
   input wire logic data_req,
   input wire logic media_we,
   // Completion
   input wire logic buf_ok,
   input wire logic done,
   input wire logic [7:0] status,
   input wire logic [7:0] sense_code
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_req_end;
      data_req ##1 !data_req;
   endsequence
   a_byte_write: assert property (data_valid && data_req |=> media_we) else $error("no write");
   a_write_cause: assert property (media_we |-> $past(data_req)) else $error("stray write");
   a_end_done: assert property (s_req_end |=> done && status == STAT_GOOD) else $error("no end");
   a_buf_done: assert property (buf_ok |=> done && status == STAT_GOOD) else $error("no done");
   a_done_pulse: assert property (done |=> !done) else $error("done held");
   a_bad_sense: assert property (done && status == STAT_CHECK |-> sense_code != 8'h00)
      else $error("no sense");
   a_good_sense: assert property (done && status == STAT_GOOD |-> sense_code == 8'h00)
      else $error("bad sense");
   a_err_quiet: assert property (done && status == STAT_CHECK |-> !media_we && !data_req)
      else $error("error moved data");
endmodule
bind wlch_write_long wlch_properties u_wlch_properties (.*);
`default_nettype wire

//--- verification/wlch_write_long_tb.sv
// Purpose: Bench for the raw write handler
// Assumes: Clock enable held high
// Notes: Partner model feeds data out
`timescale 1ns/1ns
`default_nettype none
module wlch_write_long_tb;
   import wlch_pkg::*;
   logic mclk = 0, rst = 1, cdb_valid = 0, slow = 0, data_valid, data_req, media_we, media_ecc;
   logic buf_ok, done, last_e;
   logic [7:0] cdb_byte = 8'h00, media_data, status, sense_key, sense_code, data_byte;
   logic [31:0] media_addr, last_a, exp_base;
   logic [2:0] lun;
   int mismatches = 0, checked = 0, nwr = 0, nok = 0;
   wlch_write_long u_wlch_write_long (.*, .clk_en(1'b1));
   wlch_initiator u_wlch_initiator (.*);
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk) begin
      if (media_we === 1'b1) begin
         {last_e, last_a} = {media_ecc, media_addr};
         chk(media_addr, exp_base + 32'(nwr));
         chk({media_ecc, media_data}, {1'(nwr >= PHYS_SECTOR_BYTES), 8'(nwr) ^ 8'h5a});
      end
      nwr += media_we;
      nok += buf_ok;
   end
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) $display("FAIL %0t got %h exp %h", $time, got, exp);
      mismatches += int'(got !== exp);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] blk, input logic [15:0] len);
      logic [79:0] b;
      b = {op, 8'ha0, blk, 8'h00, len, 8'h00};
      nwr = 0;
      nok = 0;
      cdb_valid = 1;
      for (int i = 9; i >= 0; i--) begin
         cdb_byte = b[i*8 +: 8];
         #40;
      end
      cdb_valid = 0;
      for (int i = 0; i < 2000 && done !== 1'b1; i++) #40;
      chk(done, 1);
   endtask
   task automatic t_raw(input logic [7:0] op, input logic [31:0] blk, input logic [15:0] len);
      exp_base = blk * PHYS_SECTOR_BYTES;
      cmd(op, blk, len);
      chk(last_a, blk * PHYS_SECTOR_BYTES + 32'h205);
      chk({status, lun, last_e}, {STAT_GOOD, 3'h5, 1'b1});
      chk(nwr, 518);
      $display("raw write %h done", op);
   endtask
   task automatic t_bad;
      cmd(OP_RAW_WR_VU, PHYS_SECTOR_COUNT, 16'h0000);
      chk({status, sense_key, sense_code, 8'(nwr)},
         {STAT_CHECK, SENSE_ILLEGAL_REQ, ASC_BAD_ADDR, 8'h00});
      $display("bad address done");
   endtask
   task automatic t_buf(input logic [15:0] len, input logic ok);
      cmd(OP_BUF_WR, 32'h0, len);
      chk({status, sense_key, sense_code, 8'(nok)},
         ok ? {STAT_GOOD, 24'h000001} : {STAT_CHECK, SENSE_ILLEGAL_REQ, ASC_BAD_FIELD, 8'h00});
      $display("buffer length %h done", len);
   endtask
   initial begin
      #61 rst = 0;
      t_raw(OP_RAW_WR_VU, 32'h3, 16'h0000);
      slow = 1;
      t_raw(OP_RAW_WR_STD, PHYS_SECTOR_COUNT - 1, 16'h0000);
      t_bad;
      t_buf(BUF_SIZE + 16'h4, 1);
      t_buf(BUF_SIZE + 16'h5, 0);
      complete_run;
   end
   initial begin
      #200000 mismatches++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run;
   end
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
endmodule
`default_nettype wire
